// [core/tbit_pkg.sv]
// package: constants and carrier types of the timebase interval timer
package tbit_pkg;
  // -------------------------------------------------------------
  // counter geometry
  // -------------------------------------------------------------
  localparam int unsigned CNT_WIDTH = 18;  // timebase counter width

  // interval taps: counter bit whose carry marks 2^n oscillator periods
  // (one count = two oscillator periods, so tap bit = n - 2)
  localparam int unsigned IVL_TAP0 = 10;  // 2^12 periods
  localparam int unsigned IVL_TAP1 = 12;  // 2^14 periods
  localparam int unsigned IVL_TAP2 = 14;  // 2^16 periods
  localparam int unsigned IVL_TAP3 = 17;  // 2^19 periods

  // stabilization delay clock taps
  localparam int unsigned STB_TAP0 = 8;   // 2^10 periods
  localparam int unsigned STB_TAP1 = 11;  // 2^13 periods
  localparam int unsigned STB_TAP2 = 13;  // 2^15 periods
  localparam int unsigned STB_TAP3 = 15;  // 2^17 periods

  // interrupt identity toward the interrupt logic
  localparam logic [7:0]  IRQ_NUMBER   = 8'h24;       // request #36
  localparam logic [23:0] IRQ_VECTOR   = 24'hffff6c;  // vector table entry
  localparam logic [3:0]  IRQ_LVL_REG  = 4'hc;        // level register index 12
  localparam logic        IRQ_EXT_SVC  = 1'b0;        // no extended_io_service

  localparam logic [CNT_WIDTH-1:0] CNT_RESET = '0;    // counter reset value

  // tap selection code
  typedef logic [1:0] tbit_sel_t;

  // clocks handed to the consumers
  typedef struct packed {
    logic stbClk;    // stabilization delay tap level
    logic wdtClk;    // watchdog count tap level
    logic wdtCarry;  // one-cycle carry pulse of the watchdog tap
  } tbit_taps_t;

  // interrupt request bundle
  typedef struct packed {
    logic        req;     // request level
    logic [7:0]  number;  // request number
    logic [23:0] vector;  // vector address
    logic [3:0]  lvlReg;  // timebase_irq_level_reg index
    logic        extSvc;  // extended_io_service allowed
  } tbit_irq_t;
endpackage : tbit_pkg

// [core/tbit_tap_mux.sv]
// tap selector: picks one of four counter bits and flags its falling edge
`timescale 1ns/1ps
`default_nettype none
module tbit_tap_mux #(
  parameter int unsigned WIDTH = tbit_pkg::CNT_WIDTH,
  parameter int unsigned TAP0  = 0,
  parameter int unsigned TAP1  = 1,
  parameter int unsigned TAP2  = 2,
  parameter int unsigned TAP3  = 3
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [WIDTH-1:0]   count,
  input  wire logic [WIDTH-1:0]   countNext,
  input  wire tbit_pkg::tbit_sel_t sel,
  output var  logic               tapLevel,
  output logic                    tapCarry
);
  logic [3:0] tapsNow;   // current tap bits
  logic [3:0] tapsNext;  // tap bits after this edge
  logic       tap_d;     // next registered level
  logic       tap_q;     // registered level

  // -------------------------------------------------------------
  // tap gather
  // -------------------------------------------------------------
  assign tapsNow  = {count[TAP3], count[TAP2], count[TAP1], count[TAP0]};
  assign tapsNext = {countNext[TAP3], countNext[TAP2], countNext[TAP1], countNext[TAP0]};

  // carry: selected bit falls 1 to 0 on the coming edge
  assign tapCarry = tapsNow[sel] & ~tapsNext[sel];

  always_comb begin
    tap_d = tapsNext[sel];  // level follows counter
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tap_q <= 1'b0;
    end else begin
      tap_q <= tap_d;
    end
  end

  assign tapLevel = tap_q;
endmodule : tbit_tap_mux
`default_nettype wire

// [core/timebase_interval_timer.sv]
// timebase interval timer: free counter, interval flag and clock taps
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - eighteen-bit counter, one step per main clock
// - interval request at one of four taps
// - stabilization delay clock from four taps
// - watchdog count clock from four taps
// - serves stabilization and watchdog logic
// - request presented as number thirty-six
// - fixed vector, level register twelve, no extended_io_service
// - carry feeds watchdog; clearing restarts period
module timebase_interval_timer #(
  parameter int unsigned WIDTH = tbit_pkg::CNT_WIDTH
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                mainClkEn,
  input  wire logic                counterClear,
  input  wire tbit_pkg::tbit_sel_t intervalSel,
  input  wire tbit_pkg::tbit_sel_t stabSel,
  input  wire tbit_pkg::tbit_sel_t wdtSel,
  input  wire logic                irqEnable,
  input  wire logic                irqFlagClear,
  output var  logic [WIDTH-1:0]    count,
  output var  logic                irqFlag,
  output tbit_pkg::tbit_irq_t      irqOut,
  output tbit_pkg::tbit_taps_t     taps
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [WIDTH-1:0] cnt_d;         // counter next value
  logic [WIDTH-1:0] cnt_q;         // counter
  logic             flag_d;        // interval flag next
  logic             flag_q;        // interval flag
  logic             ivlCarry;      // interval tap carry pulse
  logic             stbLevel;      // stabilization tap level
  logic             wdtLevel;      // watchdog tap level
  logic             wdtCarry;      // watchdog tap carry pulse
  logic             ivlCarryRaw;   // interval tap carry before clear gating
  logic             wdtCarryRaw;   // watchdog tap carry before clear gating

  // -------------------------------------------------------------
  // counter next value
  // -------------------------------------------------------------
  // mainClkEn marks each main clock (oscillator / 2) step
  always_comb begin
    cnt_d = cnt_q;
    if (counterClear) begin
      cnt_d = tbit_pkg::CNT_RESET;           // clear restarts every period
    end else if (mainClkEn) begin
      cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};  // free-running step
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= tbit_pkg::CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // -------------------------------------------------------------
  // tap selectors
  // -------------------------------------------------------------
  // interval request tap
  tbit_tap_mux #(
    .WIDTH (WIDTH),
    .TAP0  (tbit_pkg::IVL_TAP0),
    .TAP1  (tbit_pkg::IVL_TAP1),
    .TAP2  (tbit_pkg::IVL_TAP2),
    .TAP3  (tbit_pkg::IVL_TAP3)
  ) u_ivl (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .count     (cnt_q),
    .countNext (cnt_d),
    .sel       (intervalSel),
    .tapLevel  (),
    .tapCarry  (ivlCarryRaw)
  );

  // stabilization delay clock
  tbit_tap_mux #(
    .WIDTH (WIDTH),
    .TAP0  (tbit_pkg::STB_TAP0),
    .TAP1  (tbit_pkg::STB_TAP1),
    .TAP2  (tbit_pkg::STB_TAP2),
    .TAP3  (tbit_pkg::STB_TAP3)
  ) u_stb (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .count     (cnt_q),
    .countNext (cnt_d),
    .sel       (stabSel),
    .tapLevel  (stbLevel),
    .tapCarry  ()
  );

  // watchdog count clock, same taps as interval
  tbit_tap_mux #(
    .WIDTH (WIDTH),
    .TAP0  (tbit_pkg::IVL_TAP0),
    .TAP1  (tbit_pkg::IVL_TAP1),
    .TAP2  (tbit_pkg::IVL_TAP2),
    .TAP3  (tbit_pkg::IVL_TAP3)
  ) u_wdt (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .count     (cnt_q),
    .countNext (cnt_d),
    .sel       (wdtSel),
    .tapLevel  (wdtLevel),
    .tapCarry  (wdtCarryRaw)
  );

  // -------------------------------------------------------------
  // carry gating
  // -------------------------------------------------------------
  // a counter clear drops every tap to zero without a real carry;
  // letting that fall through would set the flag and advance the
  // watchdog, shortening its period instead of restarting it
  assign ivlCarry = ivlCarryRaw & ~counterClear;
  assign wdtCarry = wdtCarryRaw & ~counterClear;

  // -------------------------------------------------------------
  // interval flag
  // -------------------------------------------------------------
  // set wins over a clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (irqFlagClear) begin
      flag_d = 1'b0;                         // software clear
    end
    if (ivlCarry) begin
      flag_d = 1'b1;                         // interval reached
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign count   = cnt_q;
  assign irqFlag = flag_q;

  always_comb begin
    irqOut.req    = flag_q & irqEnable;      // gated request
    irqOut.number = tbit_pkg::IRQ_NUMBER;
    irqOut.vector = tbit_pkg::IRQ_VECTOR;
    irqOut.lvlReg = tbit_pkg::IRQ_LVL_REG;
    irqOut.extSvc = tbit_pkg::IRQ_EXT_SVC;
  end

  always_comb begin
    taps.stbClk   = stbLevel;
    taps.wdtClk   = wdtLevel;
    taps.wdtCarry = wdtCarry;                // to watchdog 2-bit counter
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  // counter and taps
  a_count_step: assert property (@(posedge sys_clk) disable iff (reset)
    (mainClkEn && !counterClear) |=> (cnt_q == $past(cnt_q) + 1'b1))
    else $error("counter did not step");
  a_count_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (!mainClkEn && !counterClear) |=> $stable(cnt_q))
    else $error("counter moved without main clock");
  a_clear_restart: assert property (@(posedge sys_clk) disable iff (reset)
    counterClear |=> (cnt_q == '0) ##1 !wdtCarry [*2])
    else $error("clear did not restart count");
  a_wdt_carry: assert property (@(posedge sys_clk) disable iff (reset)
    (wdtSel == 2'h0 && wdtCarry) |=> (cnt_q[tbit_pkg::IVL_TAP0:0] == '0))
    else $error("watchdog carry off tap");
  a_wdt_level: assert property (@(posedge sys_clk) disable iff (reset)
    (wdtSel == 2'h0) |=> (wdtLevel == cnt_q[tbit_pkg::IVL_TAP0]))
    else $error("watchdog tap level wrong");
  a_stb_level: assert property (@(posedge sys_clk) disable iff (reset)
    (stabSel == 2'h0) |=> (stbLevel == cnt_q[tbit_pkg::STB_TAP0]))
    else $error("stabilization tap wrong");
  // flag and request
  a_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
    (mainClkEn && !counterClear && intervalSel == 2'h0
     && cnt_q[tbit_pkg::IVL_TAP0:0] == '1) |=> flag_q)
    else $error("interval flag missed");
  a_flag_top: assert property (@(posedge sys_clk) disable iff (reset)
    (mainClkEn && !counterClear && intervalSel == 2'h3 && cnt_q == '1) |=> flag_q)
    else $error("longest interval flag missed");
  a_clear_no_flag: assert property (@(posedge sys_clk) disable iff (reset)
    (counterClear && !flag_q) |=> !flag_q)
    else $error("counter clear raised the flag");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
    (flag_q && !irqFlagClear) |=> flag_q)
    else $error("flag dropped without clear");
  a_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
    (irqFlagClear && !ivlCarry) |=> !flag_q)
    else $error("flag clear ignored");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (reset)
    irqOut.req == (flag_q && irqEnable))
    else $error("request not gated by enable");
  a_irq_ident: assert property (@(posedge sys_clk) disable iff (reset)
    irqOut.number == 8'h24 && irqOut.vector == 24'hffff6c && !irqOut.extSvc)
    else $error("wrong request identity");

  c_flag_set:   cover property (@(posedge sys_clk) disable iff (reset) $rose(flag_q));
  c_irq_out:    cover property (@(posedge sys_clk) disable iff (reset) $rose(irqOut.req));
  c_set_clear:  cover property (@(posedge sys_clk) disable iff (reset) ivlCarry && irqFlagClear);
  c_wdt_carry:  cover property (@(posedge sys_clk) disable iff (reset) wdtCarry);
  c_clear_high: cover property (@(posedge sys_clk) disable iff (reset) counterClear && wdtLevel);
endmodule : timebase_interval_timer
`default_nettype wire

// [tb/tbit_far_model.sv]
// far-side model: watchdog two-bit counter and stabilization clock edge counter
`timescale 1ns/1ps
`default_nettype none
module tbit_far_model (
  input  wire logic                 sys_clk,
  input  wire logic                 clr,
  input  wire tbit_pkg::tbit_taps_t taps,
  output var  logic [1:0]           wdtCount,
  output var  logic [7:0]           stbRises
);
  logic stbPrev;  // stabilization level seen at the last edge
  // ---------------------------------------------------------
  // consumers of the timebase taps
  // ---------------------------------------------------------
  always @(posedge sys_clk) begin
    stbPrev <= taps.stbClk;
    if (clr) begin
      wdtCount <= 2'h0;
      stbRises <= 8'h0;
    end else begin
      // watchdog counts carry pulses only
      if (taps.wdtCarry) begin
        wdtCount <= wdtCount + 2'h1;
      end
      // delay logic counts rising edges of its clock
      if (taps.stbClk && !stbPrev) begin
        stbRises <= stbRises + 8'h1;
      end
    end
  end
endmodule : tbit_far_model
`default_nettype wire

// [tb/timebase_interval_timer_tb_top.sv]
// testbench: interval, tap and flag behaviour of the timebase timer
`timescale 1ns/1ps
`default_nettype none
module timebase_interval_timer_tb_top;
  // ---------------------------------------------------------
  // signals
  // ---------------------------------------------------------
  logic                 sys_clk, reset, mainClkEn, counterClear;
  logic                 irqEnable, irqFlagClear, pClr;
  tbit_pkg::tbit_sel_t  intervalSel, stabSel, wdtSel;
  logic [17:0]          count;
  logic                 irqFlag;
  tbit_pkg::tbit_irq_t  irqOut;
  tbit_pkg::tbit_taps_t taps;
  logic [1:0]           wdtCount;
  logic [7:0]           stbRises;
  int                   fail_count, cmp_count, n;
  // row: selection codes, then what stands when the flag first appears
  typedef struct packed {
    logic [1:0]  ivl;    // interval selection
    logic [1:0]  stb;    // stabilization selection
    logic [1:0]  wdt;    // watchdog selection
    logic [31:0] cnt;    // counter value at first flag
    logic [7:0]  rises;  // stabilization clock rises seen
    logic [1:0]  wdts;   // watchdog carries seen
    logic        lvl;    // stabilization clock level
  } tbit_row_t;
  tbit_row_t rows [4] = '{'{2'h0, 2'h0, 2'h0, 32'h800, 8'h4, 2'h1, 1'h0},
                          '{2'h1, 2'h1, 2'h1, 32'h2000, 8'h2, 2'h1, 1'h0},
                          '{2'h2, 2'h2, 2'h2, 32'h8000, 8'h2, 2'h1, 1'h0},
                          '{2'h2, 2'h3, 2'h3, 32'h8000, 8'h0, 2'h0, 1'h1}};

  timebase_interval_timer u_dut (.sys_clk(sys_clk), .reset(reset), .mainClkEn(mainClkEn),
    .counterClear(counterClear), .intervalSel(intervalSel), .stabSel(stabSel),
    .wdtSel(wdtSel), .irqEnable(irqEnable), .irqFlagClear(irqFlagClear), .count(count),
    .irqFlag(irqFlag), .irqOut(irqOut), .taps(taps));
  tbit_far_model u_far (.sys_clk(sys_clk), .clr(pClr), .taps(taps), .wdtCount(wdtCount),
    .stbRises(stbRises));

  // ---------------------------------------------------------
  // clock, watchdog, helpers
  // ---------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    fail_count++;
    report_and_stop();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial begin
    reset        <= 1'b1;
    mainClkEn    <= 1'b1;
    pClr         <= 1'b1;
    counterClear <= 1'b0;
    irqEnable    <= 1'b0;
    irqFlagClear <= 1'b0;
    {intervalSel, stabSel, wdtSel} <= 6'h00;
    fail_count = 0;
    cmp_count = 0;
    // reset stands for two edges and is released on the second
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1 chk("reset count", count, 32'h0);
    chk("reset flag", irqFlag, 32'h0);
    // one row per selection set, each timed from a cleared counter
    foreach (rows[i]) begin
      @(posedge sys_clk);
      {counterClear, irqFlagClear, pClr} <= 3'b111;
      {intervalSel, stabSel, wdtSel} <= {rows[i].ivl, rows[i].stb, rows[i].wdt};
      @(posedge sys_clk);
      {counterClear, irqFlagClear, pClr} <= 3'b000;
      #1;
      for (n = 0; n < 40000 && irqFlag !== 1'b1; n++) begin
        @(posedge sys_clk);
        #1;
      end
      chk("interval count", count, rows[i].cnt);
      chk("wdt carries", wdtCount, rows[i].wdts);
      chk("stb rises", stbRises, rows[i].rises);
      chk("stb level", taps.stbClk, rows[i].lvl);
      chk("req gated", irqOut.req, 32'h0);
    end
    // counter clear while the watchdog tap is high must not carry
    @(posedge sys_clk);
    {counterClear, irqFlagClear, pClr} <= 3'b111;
    {intervalSel, stabSel, wdtSel} <= 6'h00;
    @(posedge sys_clk);
    {counterClear, irqFlagClear, pClr} <= 3'b000;
    repeat (1024) @(posedge sys_clk);
    counterClear <= 1'b1;
    #1 chk("wdt level", taps.wdtClk, 32'h1);
    @(posedge sys_clk);
    counterClear <= 1'b0;
    #1 chk("clear count", count, 32'h0);
    chk("clear no carry", wdtCount, 32'h0);
    chk("clear no flag", irqFlag, 32'h0);
    // flag clear in the very cycle of the carry: the set wins
    repeat (2047) @(posedge sys_clk);
    irqFlagClear <= 1'b1;
    @(posedge sys_clk);
    irqFlagClear <= 1'b0;
    #1 chk("set wins", irqFlag, 32'h1);
    chk("carry count", count, 32'h800);
    // enable, sticky flag, clear and hold of the counter
    @(posedge sys_clk);
    {irqEnable, mainClkEn, counterClear} <= 3'b101;
    @(posedge sys_clk);
    counterClear <= 1'b0;
    #1 chk("req on", irqOut.req, 32'h1);
    repeat (4) @(posedge sys_clk);
    #1 chk("held count", count, 32'h0);
    chk("sticky flag", irqFlag, 32'h1);
    @(posedge sys_clk);
    {mainClkEn, irqFlagClear} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    irqFlagClear <= 1'b0;
    #1 chk("step count", count, 32'h2);
    chk("flag cleared", irqFlag, 32'h0);
    chk("req off", irqOut.req, 32'h0);
    @(posedge sys_clk);
    counterClear <= 1'b1;
    @(posedge sys_clk);
    counterClear <= 1'b0;
    #1 chk("clear wins", count, 32'h0);
    chk("number", irqOut.number, 32'h24);
    chk("vector", irqOut.vector, 32'hffff6c);
    chk("level reg", irqOut.lvlReg, 32'hc);
    chk("ext svc", irqOut.extSvc, 32'h0);
    // reset in mid-run while counting, then the first step after it
    repeat (300) @(posedge sys_clk);
    reset <= 1'b1;
    #1 chk("stb level high", taps.stbClk, 32'h1);
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    #1 chk("mid reset count", count, 32'h0);
    chk("mid reset level", taps.stbClk, 32'h0);
    @(posedge sys_clk);
    #1 chk("first step", count, 32'h1);
    report_and_stop();
  end
endmodule : timebase_interval_timer_tb_top
`default_nettype wire
